// File: tac_checker.sv
// Purpose: Link checks between the reader end and the tag end
// Assumes: One clock, sync active-high reset, frame symbols sent back to back
// Notes: Frame head tracking breaks if a sender ever leaves gaps in a frame
`timescale 1ns/1ps
`default_nettype none

module tac_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic fid_req,
    input wire logic fid_byp,
    input wire tac_pkg::tac_max_e fid_max,
    input wire logic sym_valid,
    input wire logic [3:0] sym_nib,
    input wire logic resp_valid,
    input wire tac_pkg::tac_resp_e resp_kind,
    input wire logic [4:0] resp_addr,
    input wire logic [2:0] resp_tc,
    input wire logic mod_on
);
    import tac_pkg::*;
    typedef struct packed {
        logic [3:0] run;
        logic [3:0] head0;
        logic [3:0] head1;
        logic [3:0] last;
    } tac_chk_s;
    tac_chk_s chk_q;
    tac_chk_s chk_d;

    // Length, first two and last nibble of the latest frame
    always_comb begin
        chk_d = chk_q;
        chk_d.run = 4'h0;
        if (sym_valid) begin
            chk_d.run = (chk_q.run == 4'hF) ? 4'hF : chk_q.run + 4'h1; // Saturate, never wrap
            chk_d.last = sym_nib;
            chk_d.head0 = (chk_q.run == 4'h0) ? sym_nib : chk_q.head0;
            chk_d.head1 = (chk_q.run == 4'h1) ? sym_nib : chk_q.head1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chk_q <= 16'h0000;
        end else begin
            chk_q <= chk_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    read_frame_a: assert property (
        resp_valid && resp_kind == TAC_RSP_READ |-> chk_q.run == 4'h3
        && chk_q.head0[3:1] == 3'h6 && resp_addr == {chk_q.head0[0], chk_q.head1}
        && chk_q.last == (chk_q.head0 ^ chk_q.head1))
        else $error("read answer without a well formed read frame");
    write_frame_a: assert property (
        resp_valid && resp_kind == TAC_RSP_WRITE |-> chk_q.run == 4'hE
        && chk_q.head0[3:1] == 3'h5 && resp_addr == {chk_q.head0[0], chk_q.head1})
        else $error("write answer without a fourteen symbol write frame");
    finish_code_a: assert property (
        resp_valid && resp_kind == TAC_RSP_FINISH |-> chk_q.run == 4'h3
        && chk_q.head0 == 4'hE && chk_q.head1 == 4'hA)
        else $error("finish answer without the finish frame");
    flag_code_a: assert property (
        resp_valid && resp_kind == TAC_RSP_FLAG |-> chk_q.run == 4'h3
        && chk_q.head0 == 4'hF && chk_q.head1 inside {4'h2, 4'h3, 4'h4, 4'h5})
        else $error("flag answer for an address outside the flag set");
    finish_sleep_a: assert property (
        resp_valid && resp_kind == TAC_RSP_FINISH |-> ##[0:2] !mod_on)
        else $error("modulator still on after finish");
    sleep_hold_a: assert property (
        !mod_on |=> !mod_on)
        else $error("sleeping tag woke without reset");
    sleep_quiet_a: assert property (
        !mod_on && !$past(mod_on) |-> !resp_valid)
        else $error("sleeping tag answered");
    count_step_a: assert property (
        $changed(resp_tc) |-> resp_tc == $past(resp_tc) + 3'h1 || resp_tc == 3'h0)
        else $error("transmit counter moved by more than one");
    bypass_cause_a: assert property (
        resp_valid && resp_kind == TAC_RSP_BYPASS |-> $past(fid_byp))
        else $error("bypass answer without a bypass request");
endmodule : tac_checker

`default_nettype wire

// File: tac_link_if.sv
// Purpose: Symbol level link between reader and tag
// Assumes: One clock; every signal is a plain level or one-cycle pulse
// Notes: Gap-pulse commands are abstracted to single pulses
`timescale 1ns/1ps
`default_nettype none

interface tac_link_if;
    import tac_pkg::*;
    logic fid_req;
    logic fid_byp;
    tac_max_e fid_max;
    logic sym_valid;
    logic [3:0] sym_nib;
    logic resp_valid;
    tac_resp_e resp_kind;
    logic [4:0] resp_addr;
    logic [2:0] resp_tc;
    logic mod_on;

    modport tag (input fid_req, fid_byp, fid_max, sym_valid, sym_nib,
        output resp_valid, resp_kind, resp_addr, resp_tc, mod_on);
    modport rdr (output fid_req, fid_byp, fid_max, sym_valid, sym_nib,
        input resp_valid, resp_kind, resp_addr, resp_tc, mod_on);
endinterface : tac_link_if

`default_nettype wire

// File: tac_params.svh
// Purpose: Named constants of the tag anticollision command controller
// Assumes: 100 MHz clock, one nibble per symbol strobe
// Notes: Definitions only
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH

// Command codes and special addresses
`define TAC_CODE_READ 3'h6
`define TAC_CODE_WRITE 3'h5
`define TAC_CODE_SPECIAL 3'h7
`define TAC_ADDR_FINISH 5'h0A
`define TAC_ADDR_SET_TI 5'h12
`define TAC_ADDR_SET_QI 5'h13
`define TAC_ADDR_CLR_TI 5'h14
`define TAC_ADDR_CLR_QI 5'h15

// Match code types carried in the third symbol
`define TAC_MC_SLEEP 3'h1
`define TAC_MC_PROCESS 3'h2

// Frame lengths in symbols
`define TAC_LEN_SHORT 4'h3
`define TAC_LEN_WRITE 4'hE

// Check field seeds
`define TAC_CRC_INIT 16'hFFFF
`define TAC_CRC_POLY 16'h1021

// Listening window
`define TAC_CLK_MHZ 100
`define TAC_LISTEN_US 1000
`define TAC_LISTEN_CYC (`TAC_LISTEN_US * `TAC_CLK_MHZ)
`define TAC_TIMER_W 17

// Power-up flag values and arbitrary tag id byte
`define TAC_QI_INIT 1'h1
`define TAC_TI_INIT 1'h0
`define TAC_TAG_ID8 8'h5A

`endif

// File: tac_pkg.sv
// Purpose: Types and check functions shared by tag and reader ends
// Assumes: tac_params.svh holds every numeric constant
// Notes: Functions used by both ends live here
`default_nettype none
`include "tac_params.svh"

package tac_pkg;
    typedef enum logic [1:0] {TAC_MAX_1, TAC_MAX_2, TAC_MAX_4} tac_max_e;
    typedef enum logic [2:0] {TAC_DET_WAIT, TAC_DET_LISTEN, TAC_PROC, TAC_SLEEP,
        TAC_REACT_WAIT, TAC_REACT_LISTEN} tac_loop_e;
    typedef enum logic [2:0] {TAC_RSP_IDENT, TAC_RSP_BYPASS, TAC_RSP_READ, TAC_RSP_WRITE,
        TAC_RSP_FLAG, TAC_RSP_FINISH} tac_resp_e;
    typedef enum logic [2:0] {TAC_OP_REQ, TAC_OP_BYPASS, TAC_OP_MATCH, TAC_OP_READ,
        TAC_OP_WRITE, TAC_OP_SPECIAL} tac_op_e;

    // Elapse test on the rolling modulo-8 counter
    function automatic logic tac_elapsed(input logic [2:0] tc, input tac_max_e mx);
        unique case (mx)
            TAC_MAX_1: tac_elapsed = 1'b1;
            TAC_MAX_2: tac_elapsed = ~tc[0];
            default: tac_elapsed = (tc == 3'h4) || (tc == 3'h7);
        endcase
    endfunction : tac_elapsed

    // Parity nibble over code and address
    function automatic logic [3:0] tac_parity(input logic [7:0] hdr);
        tac_parity = hdr[7:4] ^ hdr[3:0];
    endfunction : tac_parity

    // Match code parity bit over id byte and type
    function automatic logic tac_mc_par(input logic [7:0] id8, input logic [2:0] typ);
        tac_mc_par = ^{id8, typ};
    endfunction : tac_mc_par

    // Bitwise CRC-16 over code, address and data, msb first
    function automatic logic [15:0] tac_crc(input logic [39:0] msg);
        logic [15:0] c;
        logic fb;
        c = `TAC_CRC_INIT;
        for (int i = 39; i >= 0; i--) begin
            fb = c[15] ^ msg[i];
            c = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ `TAC_CRC_POLY;
            end
        end
        tac_crc = c;
    endfunction : tac_crc
endpackage : tac_pkg

`default_nettype wire

// File: tac_reader.sv
// Purpose: Reader end: builds and sends commands, captures tag answers
// Assumes: One symbol per clock while sending
// Notes: Register file over a plain strobe port
`timescale 1ns/1ps
`default_nettype none
`include "tac_params.svh"

module tac_reader (
    input wire logic clock,
    input wire logic rst,
    tac_link_if.rdr link,
    input wire logic [2:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    import tac_pkg::*;

    // Word offsets of the reader's own registers
    localparam logic [2:0] A_CMD = 3'h0;
    localparam logic [2:0] A_DATA = 3'h1;
    localparam logic [2:0] A_STAT = 3'h2;

    typedef struct packed {
        logic [31:0] data;
        logic [55:0] nibs;
        logic [3:0] len;
        logic [3:0] idx;
        logic busy;
        logic fid_req;
        logic fid_byp;
        tac_max_e fmax;
        logic sv;
        logic [3:0] nib;
        logic got;
        tac_resp_e kind;
        logic [4:0] raddr;
        logic [2:0] rtc;
        logic [31:0] rdata;
    } tac_rdr_s;

    tac_rdr_s q, d;
    tac_op_e op;
    logic [7:0] hdr;

    // Command word: [2:0] op, [7:3] address or match type, [15:8] id, [17:16] max
    always_comb begin
        d = q;
        d.fid_req = 1'b0;
        d.fid_byp = 1'b0;
        d.sv = 1'b0;
        d.rdata = '0;
        op = tac_op_e'(wdata[2:0]);
        hdr = {wdata[2:0] == 3'(TAC_OP_READ) ? `TAC_CODE_READ
            : wdata[2:0] == 3'(TAC_OP_WRITE) ? `TAC_CODE_WRITE : `TAC_CODE_SPECIAL,
            wdata[7:3]};
        // Send one nibble per cycle, index order
        if (q.busy) begin
            d.sv = 1'b1;
            d.nib = q.nibs[4*q.idx +: 4];
            d.idx = q.idx + 4'h1;
            d.busy = (d.idx != q.len);
        end
        if (link.resp_valid) begin
            d.got = 1'b1;
            d.kind = link.resp_kind;
            d.raddr = link.resp_addr;
            d.rtc = link.resp_tc;
        end
        if (wr && addr == A_DATA) begin
            d.data = wdata;
        end
        if (wr && addr == A_CMD && !q.busy) begin
            d.idx = 4'h0;
            d.nibs = '0;
            d.len = `TAC_LEN_SHORT;
            if (op == TAC_OP_REQ) begin
                d.fid_req = 1'b1;
                d.fmax = tac_max_e'(wdata[17:16]);
            end else if (op == TAC_OP_BYPASS) begin
                d.fid_byp = 1'b1;
            end else if (op == TAC_OP_MATCH) begin
                d.nibs[11:0] = {wdata[5:3], tac_mc_par(wdata[15:8], wdata[5:3]),
                    wdata[11:8], wdata[15:12]};
                d.busy = 1'b1;
            end else begin
                d.nibs[7:0] = {hdr[3:0], hdr[7:4]};
                if (op == TAC_OP_WRITE) begin
                    d.nibs[39:8] = q.data;
                    d.nibs[55:40] = tac_crc({hdr, q.data});
                    d.len = `TAC_LEN_WRITE;
                end else begin
                    d.nibs[11:8] = tac_parity(hdr);
                end
                d.busy = 1'b1;
            end
        end
        if (rd) begin
            unique case (addr)
                A_DATA: d.rdata = q.data;
                A_STAT: d.rdata = {19'h0, q.rtc, q.raddr, q.kind, q.got, q.busy};
                default: d.rdata = '0;
            endcase
            if (addr == A_STAT) begin
                d.got = link.resp_valid; // New answer wins over read-clear
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.fmax <= TAC_MAX_1;
            q.kind <= TAC_RSP_IDENT;
        end else begin
            q <= d;
        end
    end

    assign link.fid_req = q.fid_req;
    assign link.fid_byp = q.fid_byp;
    assign link.fid_max = q.fmax;
    assign link.sym_valid = q.sv;
    assign link.sym_nib = q.nib;
    assign rdata = q.rdata;
endmodule : tac_reader

`default_nettype wire

// File: tac_tag.sv
// Purpose: Tag end: anticollision loops and command decoder
// Assumes: Symbols and fast identify pulses arrive synchronous to clock
// Notes: Time slots, framing and memory are outside; reads/writes are pulses
// Function
// - Unacknowledged after max count: back to detection start
// - Queued tag accepts match code outside window
// - Elapse decided from rolling modulo-8 counter
// - Read/write only with processing flag set
// - Finish with flag set enters sleeping loop
// - Finish with flag clear returns to detection
// - Fast identify during processing resets tag; here quick and initiate bits are kept, the processing flag is cleared and the quick bit picks the loop
// - Sleeping tag never modulates until reset
// - Quick-identify clear: wait bypass, reply, listen
// - Process match in window enters processing
// - Command is code, address, data, check
// - Block read is code 110, three symbols
// - Finish is code 111 address 01010
// - Flag commands set/clear initiate and quick bits
// - Code and address arrive MSN first
// - Data and check arrive LSN first
// - Check covers code, address and data
// - Sleep match sleeps in detection loops only, process match processes
// - Three-bit counter increments on missed window
// - Identify response then 1 ms listening window
// - Each symbol carries one nibble
`timescale 1ns/1ps
`default_nettype none
`include "tac_params.svh"

module tac_tag #(
    parameter int LISTEN_CYC = `TAC_LISTEN_CYC,
    parameter logic [7:0] TAG_ID8 = `TAC_TAG_ID8
) (
    input wire logic clock,
    input wire logic rst,
    tac_link_if.tag link,
    output tac_pkg::tac_loop_e loop_state,
    output logic processing_flag,
    output logic quick_identify_bit,
    output logic tag_initiates_bit,
    output logic [2:0] transmit_counter,
    output logic rd_req,
    output logic wr_req,
    output logic [4:0] req_addr,
    output logic [31:0] wr_data
);
    import tac_pkg::*;

    typedef struct packed {
        tac_loop_e loop;
        logic pos1;
        logic pf;
        logic [2:0] tc;
        tac_max_e maxc;
        logic qi;
        logic ti;
        logic [`TAC_TIMER_W-1:0] timer;
        logic [3:0] cnt;
        logic [55:0] nibs;
        logic resp_v;
        tac_resp_e kind;
        logic [4:0] addr;
        logic [31:0] wdata;
        logic rd;
        logic wr;
        logic mod_on;
    } tac_tag_s;

    localparam logic [`TAC_TIMER_W-1:0] WIN_LOAD = `TAC_TIMER_W'(LISTEN_CYC - 1);

    tac_tag_s q, d;
    logic [2:0] code;
    logic [3:0] need;
    logic done;
    logic [55:0] f;
    logic [7:0] hdr;
    logic [7:0] id8;
    logic mc_ok;
    logic chk_ok;
    logic [2:0] tc_inc;

    // Next state of the whole tag
    always_comb begin
        d = q;
        d.resp_v = 1'b0;
        d.rd = 1'b0;
        d.wr = 1'b0;
        done = 1'b0;
        code = (q.cnt == 4'h0) ? link.sym_nib[3:1] : q.nibs[3:1];
        need = (q.loop == TAC_PROC && code == `TAC_CODE_WRITE) ? `TAC_LEN_WRITE
            : `TAC_LEN_SHORT;
        // Assemble nibbles by index; reactivation only listens in its window
        if (link.sym_valid && q.loop != TAC_SLEEP && q.loop != TAC_REACT_WAIT) begin
            d.nibs[4*q.cnt +: 4] = link.sym_nib;
            d.cnt = q.cnt + 4'h1;
            if (d.cnt == need) begin
                done = 1'b1;
                d.cnt = 4'h0;
            end
        end
        f = d.nibs;
        hdr = {f[3:0], f[7:4]};
        id8 = {f[3:0], f[7:4]};
        mc_ok = (f[8] == tac_mc_par(id8, f[11:9]));
        chk_ok = (code == `TAC_CODE_WRITE)
            ? (f[55:40] == tac_crc({hdr, f[39:8]}))
            : (f[11:8] == tac_parity(hdr));
        tc_inc = q.tc + 3'h1;
        if (q.timer != '0) begin
            d.timer = q.timer - `TAC_TIMER_W'(1);
        end
        unique case (q.loop)
            TAC_DET_WAIT, TAC_DET_LISTEN: begin
                if (link.fid_req) begin
                    d.pos1 = 1'b0;
                    d.maxc = link.fid_max;
                    d.resp_v = 1'b1;
                    d.kind = TAC_RSP_IDENT;
                    d.loop = TAC_DET_LISTEN;
                    d.timer = WIN_LOAD;
                    d.cnt = 4'h0;
                end else if (done && mc_ok && f[11:9] == `TAC_MC_PROCESS) begin
                    d.pf = (id8 == TAG_ID8); // Wrong id follows along
                    d.loop = TAC_PROC;
                end else if (done && mc_ok && f[11:9] == `TAC_MC_SLEEP && id8 == TAG_ID8) begin
                    d.loop = TAC_SLEEP;
                end else if (q.loop == TAC_DET_LISTEN && q.timer == '0) begin
                    d.tc = q.pos1 ? q.tc : tc_inc;
                    if (tac_elapsed(d.tc, q.maxc)) begin
                        d.pos1 = 1'b1;
                        d.loop = TAC_DET_WAIT;
                    end else begin
                        d.resp_v = 1'b1;
                        d.kind = TAC_RSP_IDENT;
                        d.timer = WIN_LOAD;
                    end
                end
            end
            TAC_PROC: begin
                if (link.fid_req || link.fid_byp) begin
                    // Treated as invalid: back to the waiting loop the quick bit selects, quick and initiate bits kept, processing flag cleared
                    d.loop = q.qi ? TAC_DET_WAIT : TAC_REACT_WAIT;
                    d.pos1 = 1'b1;
                    d.pf = 1'b0;
                    d.tc = 3'h0;
                    d.cnt = 4'h0;
                end else if (done && chk_ok) begin
                    d.addr = hdr[4:0];
                    if (code == `TAC_CODE_READ && q.pf) begin
                        d.rd = 1'b1;
                        d.resp_v = 1'b1;
                        d.kind = TAC_RSP_READ;
                    end else if (code == `TAC_CODE_WRITE && q.pf) begin
                        d.wr = 1'b1;
                        d.wdata = f[39:8];
                        d.resp_v = 1'b1;
                        d.kind = TAC_RSP_WRITE;
                    end else if (code == `TAC_CODE_SPECIAL) begin
                        if (hdr[4:0] == `TAC_ADDR_FINISH) begin
                            d.loop = q.pf ? TAC_SLEEP : TAC_DET_WAIT;
                            d.pos1 = 1'b1;
                            d.resp_v = q.pf;
                            d.kind = TAC_RSP_FINISH;
                        end else if (q.pf) begin
                            // Flag updates are writes, so follow-along tags skip them
                            unique case (hdr[4:0])
                                `TAC_ADDR_SET_TI: d.ti = 1'b1;
                                `TAC_ADDR_SET_QI: d.qi = 1'b1;
                                `TAC_ADDR_CLR_TI: d.ti = 1'b0;
                                `TAC_ADDR_CLR_QI: d.qi = 1'b0;
                                default: ;
                            endcase
                            d.resp_v = (d.ti != q.ti) || (d.qi != q.qi) ||
                                (hdr[4:1] == 4'h9) || (hdr[4:1] == 4'hA);
                            d.kind = TAC_RSP_FLAG;
                        end
                    end
                    // Codes 0xx and 100 fall through with only the address loaded
                end
            end
            TAC_SLEEP: begin
                d.loop = TAC_SLEEP;
            end
            TAC_REACT_WAIT: begin
                if (link.fid_byp) begin
                    d.resp_v = 1'b1;
                    d.kind = TAC_RSP_BYPASS;
                    d.loop = TAC_REACT_LISTEN;
                    d.timer = WIN_LOAD;
                    d.cnt = 4'h0;
                end
            end
            TAC_REACT_LISTEN: begin
                if (done && mc_ok && id8 == TAG_ID8 && f[11:9] == `TAC_MC_PROCESS) begin
                    d.pf = 1'b1;
                    d.loop = TAC_PROC;
                end else if (q.timer == '0) begin
                    d.loop = TAC_REACT_WAIT;
                    d.cnt = 4'h0;
                end
            end
        endcase
        d.mod_on = (d.loop != TAC_SLEEP);
    end

    // State register; power-up loop follows the stored quick-identify value
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.loop <= `TAC_QI_INIT ? TAC_DET_WAIT : TAC_REACT_WAIT;
            q.pos1 <= 1'b1;
            q.maxc <= TAC_MAX_1;
            q.qi <= `TAC_QI_INIT;
            q.ti <= `TAC_TI_INIT;
            q.kind <= TAC_RSP_IDENT;
            q.mod_on <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.resp_valid = q.resp_v;
    assign link.resp_kind = q.kind;
    assign link.resp_addr = q.addr;
    assign link.resp_tc = q.tc;
    assign link.mod_on = q.mod_on;
    assign loop_state = q.loop;
    assign processing_flag = q.pf;
    assign quick_identify_bit = q.qi;
    assign tag_initiates_bit = q.ti;
    assign transmit_counter = q.tc;
    assign rd_req = q.rd;
    assign wr_req = q.wr;
    assign req_addr = q.addr;
    assign wr_data = q.wdata;
endmodule : tac_tag

`default_nettype wire

// File: testbench.sv
// Purpose: Drives the reader register port and judges both ends
// Assumes: Short listening window; tag id byte left at its default
// Notes: The reader always forms good check fields; the checker guards only the read frame's parity nibble
`timescale 1ns/1ps
`default_nettype none
`include "tac_params.svh"

module testbench;
    import tac_pkg::*;
    localparam int LCYC = 20;
    logic clock;
    logic rst;
    logic [2:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    tac_loop_e loop_state;
    logic processing_flag;
    logic quick_identify_bit;
    logic tag_initiates_bit;
    logic [2:0] transmit_counter;
    logic rd_req;
    logic wr_req;
    logic [4:0] req_addr;
    logic [31:0] wr_data;
    logic [31:0] v;
    logic [2:0] exp_count;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_rd = 0;
    int n_wr = 0;
    int n_id = 0;
    int n_byp = 0;
    int n;
    logic [1:0] mx_tab [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
    logic [4:0] fl_tab [3] = '{`TAC_ADDR_CLR_QI, `TAC_ADDR_SET_TI, `TAC_ADDR_CLR_TI};
    logic [1:0] fl_exp [3] = '{2'b00, 2'b01, 2'b00};

    tac_link_if link ();
    tac_tag #(.LISTEN_CYC(LCYC)) u_tac_tag (.clock(clock), .rst(rst), .link(link),
        .loop_state(loop_state), .processing_flag(processing_flag),
        .quick_identify_bit(quick_identify_bit), .tag_initiates_bit(tag_initiates_bit),
        .transmit_counter(transmit_counter), .rd_req(rd_req), .wr_req(wr_req),
        .req_addr(req_addr), .wr_data(wr_data));
    tac_reader u_tac_reader (.clock(clock), .rst(rst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    tac_checker u_tac_checker (.clock(clock), .rst(rst), .fid_req(link.fid_req),
        .fid_byp(link.fid_byp), .fid_max(link.fid_max), .sym_valid(link.sym_valid),
        .sym_nib(link.sym_nib), .resp_valid(link.resp_valid), .resp_kind(link.resp_kind),
        .resp_addr(link.resp_addr), .resp_tc(link.resp_tc), .mod_on(link.mod_on));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Pulse counters and hang guard
    always @(posedge clock) begin
        cyc++;
        if (rd_req === 1'b1) n_rd++;
        if (wr_req === 1'b1) n_wr++;
        if (link.resp_valid === 1'b1 && link.resp_kind === TAC_RSP_IDENT) n_id++;
        if (link.resp_valid === 1'b1 && link.resp_kind === TAC_RSP_BYPASS) n_byp++;
        if (cyc == 8000) begin
            err_count++;
            end_sim();
        end
    end

    // Elapse table kept apart from the design's own function
    function automatic logic tb_elapsed(input logic [2:0] t, input logic [1:0] mx);
        logic [7:0] m;
        m = (mx == 2'h0) ? 8'hFF : (mx == 2'h1) ? 8'h55 : 8'h90;
        tb_elapsed = m[t];
    endfunction : tb_elapsed

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Issue one reader command and poll busy; a new command while busy is dropped
    task automatic cmd(input logic [2:0] op, input logic [4:0] a5, input logic [7:0] id,
        input logic [1:0] mx);
        int k;
        k = 0;
        wr_reg(3'h0, {14'h0, mx, id, a5, op});
        v = 32'h1;
        while (v[0] !== 1'b0 && k < 100) begin
            rd_reg(3'h2, v);
            k++;
        end
        repeat (3) @(posedge clock);
        #1;
    endtask : cmd

    task automatic ident_match(input logic [7:0] id, input logic [2:0] typ);
        cmd(3'h0, 5'h00, 8'h00, 2'h0);
        repeat (LCYC + 20) @(posedge clock);
        cmd(3'h2, {2'b00, typ}, id, 2'h0);
    endtask : ident_match

    task automatic chk_loop(input tac_loop_e l, input logic p);
        check("loop", loop_state, l);
        check("processing", processing_flag, p);
    endtask : chk_loop

    task automatic do_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        chk_loop(TAC_DET_WAIT, 1'b0);
        check("flags", {quick_identify_bit, tag_initiates_bit}, 2'b10);
        check("counter", transmit_counter, 3'h0);
        check("modulator", link.mod_on, 1'b1);
    endtask : do_reset

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        rst = 1'b1;
        addr = 3'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        do_reset();
        $display("reset test done");
        // Identify rounds; the count rolls on across rounds
        exp_count = 3'h0;
        foreach (mx_tab[i]) begin
            n = 1;
            exp_count = exp_count + 3'h1;
            while (!tb_elapsed(exp_count, mx_tab[i])) begin
                n++;
                exp_count = exp_count + 3'h1;
            end
            n_id = 0;
            cmd(3'h0, 5'h00, 8'h00, mx_tab[i]);
            repeat (n * (LCYC + 10) + 20) @(posedge clock);
            check("idents", n_id, n);
            check("counter", transmit_counter, exp_count);
            chk_loop(TAC_DET_WAIT, 1'b0);
        end
        $display("identify test done");
        // Queued tag takes its match long after the window closed
        cmd(3'h2, {2'b00, `TAC_MC_PROCESS}, `TAC_TAG_ID8, 2'h0);
        chk_loop(TAC_PROC, 1'b1);
        cmd(3'h3, 5'h03, 8'h00, 2'h0);
        check("reads", n_rd, 1);
        check("raddr", req_addr, 5'h03);
        rd_reg(3'h2, v);
        check("kind", v[4:2], TAC_RSP_READ);
        wr_reg(3'h1, 32'hA5C3_1E07);
        cmd(3'h4, 5'h1F, 8'h00, 2'h0);
        check("writes", n_wr, 1);
        check("waddr", req_addr, 5'h1F);
        check("wdata", wr_data, 32'hA5C3_1E07);
        cmd(3'h5, 5'h0B, 8'h00, 2'h0);
        check("flags", {quick_identify_bit, tag_initiates_bit}, 2'b10);
        chk_loop(TAC_PROC, 1'b1);
        foreach (fl_tab[i]) begin
            cmd(3'h5, fl_tab[i], 8'h00, 2'h0);
            check("flags", {quick_identify_bit, tag_initiates_bit}, fl_exp[i]);
        end
        $display("processing test done");
        // Quick bit now clear, so a fast identify here lands in reactivation
        cmd(3'h0, 5'h00, 8'h00, 2'h0);
        chk_loop(TAC_REACT_WAIT, 1'b0);
        cmd(3'h3, 5'h03, 8'h00, 2'h0);
        check("reads", n_rd, 1);
        cmd(3'h1, 5'h00, 8'h00, 2'h0);
        check("bypass", n_byp, 1);
        check("loop", loop_state, TAC_REACT_LISTEN);
        cmd(3'h2, {2'b00, `TAC_MC_PROCESS}, `TAC_TAG_ID8, 2'h0);
        chk_loop(TAC_PROC, 1'b1);
        cmd(3'h5, `TAC_ADDR_SET_QI, 8'h00, 2'h0);
        check("quick", quick_identify_bit, 1'b1);
        cmd(3'h5, `TAC_ADDR_FINISH, 8'h00, 2'h0);
        check("loop", loop_state, TAC_SLEEP);
        n_id = 0;
        cmd(3'h0, 5'h00, 8'h00, 2'h0);
        cmd(3'h3, 5'h03, 8'h00, 2'h0);
        check("silent", n_id, 0);
        check("reads", n_rd, 1);
        check("modulator", link.mod_on, 1'b0);
        $display("reactivation and sleep test done");
        do_reset();
        // Wrong id makes a follow-along tag that must never be read
        ident_match(8'hA5, `TAC_MC_PROCESS);
        chk_loop(TAC_PROC, 1'b0);
        cmd(3'h3, 5'h04, 8'h00, 2'h0);
        check("reads", n_rd, 1);
        cmd(3'h5, `TAC_ADDR_FINISH, 8'h00, 2'h0);
        chk_loop(TAC_DET_WAIT, 1'b0);
        ident_match(8'hA5, `TAC_MC_PROCESS);
        cmd(3'h1, 5'h00, 8'h00, 2'h0);
        chk_loop(TAC_DET_WAIT, 1'b0);
        ident_match(`TAC_TAG_ID8, `TAC_MC_SLEEP);
        check("loop", loop_state, TAC_SLEEP);
        $display("follow-along test done");
        end_sim();
    end
endmodule : testbench

`default_nettype wire
